// ===== src/lpm_pkg.sv
/*
 holds constants, register map and mode types for the low power mode and
 clock select block; assumes a 25 MHz system clock and Avalon-MM access
*/
`default_nettype none
package lpm_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // register word addresses (byte address is four times the index)
  localparam logic [5:0] REG_MIS = 6'h0C;
  localparam logic [5:0] REG_LSDT = 6'h20;
  localparam logic [5:0] REG_RAMV = 6'h21;
  localparam logic [5:0] REG_SCS = 6'h29;
  localparam logic [5:0] REG_CMD = 6'h30;
  localparam logic [5:0] REG_STAT = 6'h31;
  localparam logic [5:0] REG_IRQ = 6'h32;
  // field positions
  localparam int unsigned LOW_SPEED_FLAG_BIT = 0;
  localparam int unsigned DIRECT_TRANSFER_FLAG_BIT = 3;
  localparam int unsigned RAMV_BIT = 3;
  localparam int unsigned SUBDIV_BIT = 2;
  localparam int unsigned SUBSTOP_BIT = 3;
  localparam int unsigned CMD_STOP_BIT = 0;
  localparam int unsigned CMD_SBY_BIT = 1;
  localparam int unsigned WATCH_SEL_BIT = 2;
  localparam int unsigned IRQ_IE_BIT = 0;
  localparam int unsigned IRQ_PEND_BIT = 1;
  localparam logic [3:0] SCS_RESET = 4'h0;
  localparam logic [3:0] MIS_RESET = 4'h0;
  // instruction cycle times in ns and derived cycles
  localparam int unsigned SUB_CYC_SLOW_NS = 244000;
  localparam int unsigned SUB_CYC_FAST_NS = 122000;
  localparam int unsigned SUB_CYC_SLOW = SUB_CYC_SLOW_NS / 40;
  localparam int unsigned SUB_CYC_FAST = SUB_CYC_FAST_NS / 40;
  // frame lengths in strobe ticks, selected by two frame bits
  localparam int unsigned FRAME_T0 = 4;
  localparam int unsigned FRAME_T1 = 8;
  localparam int unsigned FRAME_T2 = 16;
  localparam int unsigned SETTLE_DEF = 8192;
  typedef enum logic [2:0] {
    LPM_ACTIVE, LPM_STANDBY, LPM_STOP, LPM_WATCH, LPM_SUBACTIVE, LPM_DIRECT
  } lpm_mode_t;
endpackage
`default_nettype wire

// ===== src/lpm_tick.sv
/*
 holds the interrupt strobe divider; assumes the mode logic drives its
 enable and cycle length through the tick interface
*/
`timescale 1ns/1ps
`default_nettype none
interface lpm_tick_if;
  logic run;
  logic [31:0] period;
  logic strobe;
  modport ctl (output run, output period, input strobe);
  modport gen (input run, input period, output strobe);
endinterface

module lpm_tick (
  input wire logic i_clk,
  input wire logic i_reset,
  lpm_tick_if.gen tk
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic strobe_r;
  logic next_strobe;
  always_comb
  begin
    next_cnt = cnt;
    next_strobe = 1'b0;
    if (!tk.run)
    begin
      next_cnt = 32'h0;
    end
    else if (cnt + 32'h1 >= tk.period)
    begin
      next_cnt = 32'h0;
      next_strobe = 1'b1;
    end
    else
    begin
      next_cnt = cnt + 32'h1;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      cnt <= 32'h0;
      strobe_r <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      strobe_r <= next_strobe;
    end
  end
  assign tk.strobe = strobe_r;
endmodule // lpm_tick
`default_nettype wire

// ===== src/lpm_ctrl.sv
/*
 holds the low power mode sequencer with clock select, frame time base and
 wake pin edge logic; assumes synchronous pins and an Avalon-MM master
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - subactive stops main oscillator, A/D off
// - subactive cycle 244 or 122 us
// - STOP/STANDBY_INSTRUCTION in subactive picks watch/direct
// - frame from prescaler, length from register
// - wake requests issued on strobe only
// - pin edge counts at second strobe
// - direct transfer waits settle then active
// - direct flag settable only in subactive
// - direct time between settle and frame+settle
// - stop exit restarts at address zero
// - ram flag zero by reset, one by pin
// - reset cancels all; cancel pin stop-only
// - reset acts from any state
// - STOP/STANDBY_INSTRUCTION is no-op with pending interrupt and ie clear
// - falling edge from sampled high-to-low
// - sub oscillator halts in stop if bit set
// - sub stop bit cleared by reset, loaded by an SCS write
module lpm_ctrl #(
  parameter int unsigned SETTLE_CYCLES = lpm_pkg::SETTLE_DEF
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_stop_cancel_pin_n,
  input wire logic i_wake_irq_pin_n,
  input wire logic i_timer_a_ovf,
  output logic o_main_osc_en,
  output logic o_sub_osc_en,
  output logic o_adc_en,
  output logic o_cpu_run,
  output logic o_restart_at_zero,
  output logic o_wake_irq,
  output logic o_timer_irq
);
  lpm_pkg::lpm_mode_t mode, next_mode;
  logic [3:0] scs, next_scs;
  logic [3:0] frame_length_register, next_mis;
  logic low_speed_flag, next_low_speed_flag, direct_transfer_flag, next_direct_transfer_flag, ramv, next_ramv;
  logic ie, next_ie, pend, next_pend, watch_sel, next_watch_sel;
  logic [31:0] settle, next_settle;
  logic [31:0] rdata, next_rdata;
  logic ack, next_ack;
  logic restart, next_restart;
  logic wake_s, next_wake_s, wake_prev, next_wake_prev;
  logic [1:0] edge_wait, next_edge_wait;
  logic wirq, next_wirq, tirq, next_tirq, tovf_hold, next_tovf_hold;
  logic [4:0] frame_ticks, next_frame_ticks;
  logic frame, wr, rd, slow_mode;
  lpm_tick_if tk ();

  function automatic logic [31:0] frame_len(input logic [1:0] sel);
    case (sel)
      2'h0: frame_len = 32'(lpm_pkg::FRAME_T0);
      2'h1: frame_len = 32'(lpm_pkg::FRAME_T1);
      default: frame_len = 32'(lpm_pkg::FRAME_T2);
    endcase
  endfunction

  lpm_tick u_tick (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .tk(tk.gen)
  );

  assign slow_mode = (mode == lpm_pkg::LPM_WATCH) || (mode == lpm_pkg::LPM_SUBACTIVE)
    || (mode == lpm_pkg::LPM_DIRECT);
  assign tk.period = scs[lpm_pkg::SUBDIV_BIT] ? 32'(lpm_pkg::SUB_CYC_FAST)
    : 32'(lpm_pkg::SUB_CYC_SLOW);
  assign tk.run = slow_mode;
  // frame ends after selected strobe count
  assign frame = tk.strobe && (32'(frame_ticks) + 32'h1 >= frame_len(frame_length_register[1:0]));
  assign wr = i_avs_write && ack;
  assign rd = i_avs_read && !ack;

  always_comb
  begin
    next_mode = mode;
    next_scs = scs;
    next_mis = frame_length_register;
    next_low_speed_flag = low_speed_flag;
    next_direct_transfer_flag = direct_transfer_flag;
    next_ramv = ramv;
    next_ie = ie;
    next_pend = pend;
    next_watch_sel = watch_sel;
    next_settle = settle;
    next_restart = 1'b0;
    next_rdata = rdata;
    next_ack = (i_avs_read || i_avs_write) && !ack;
    next_wake_s = i_wake_irq_pin_n;
    next_wake_prev = slow_mode ? (tk.strobe ? wake_s : wake_prev) : 1'b1;
    next_edge_wait = edge_wait;
    next_wirq = 1'b0;
    next_tirq = 1'b0;
    next_tovf_hold = tovf_hold | i_timer_a_ovf;
    next_frame_ticks = frame ? 5'h00 : (tk.strobe ? frame_ticks + 5'h01 : frame_ticks);
    if (!slow_mode)
    begin
      next_frame_ticks = 5'h00;
      next_edge_wait = 2'h0;
      next_tovf_hold = 1'b0;
    end
    else if (tk.strobe)
    begin
      if (wake_prev && !wake_s && edge_wait == 2'h0)
      begin
        next_edge_wait = 2'h1;
      end
      else if (edge_wait != 2'h0)
      begin
        next_edge_wait = edge_wait - 2'h1;
        if (edge_wait == 2'h1 && mode != lpm_pkg::LPM_DIRECT)
        begin
          next_wirq = 1'b1;
        end
      end
      if (tovf_hold && mode != lpm_pkg::LPM_DIRECT)
      begin
        next_tirq = 1'b1;
        next_tovf_hold = i_timer_a_ovf;
      end
    end
    if (wr)
    begin
      case (i_avs_address)
        lpm_pkg::REG_MIS: next_mis = i_avs_writedata[3:0];
        lpm_pkg::REG_LSDT:
        begin
          next_low_speed_flag = i_avs_writedata[lpm_pkg::LOW_SPEED_FLAG_BIT];
          if (mode == lpm_pkg::LPM_SUBACTIVE)
          begin
            next_direct_transfer_flag = i_avs_writedata[lpm_pkg::DIRECT_TRANSFER_FLAG_BIT];
          end
        end
        lpm_pkg::REG_RAMV: next_ramv = i_avs_writedata[lpm_pkg::RAMV_BIT];
        // divider changes expected while active only
        lpm_pkg::REG_SCS: next_scs = i_avs_writedata[3:0];
        lpm_pkg::REG_IRQ:
        begin
          next_ie = i_avs_writedata[lpm_pkg::IRQ_IE_BIT];
          next_pend = i_avs_writedata[lpm_pkg::IRQ_PEND_BIT];
          next_watch_sel = i_avs_writedata[lpm_pkg::WATCH_SEL_BIT];
        end
        lpm_pkg::REG_CMD:
        begin
          // pending interrupt with ie clear makes it a no-op
          if (!(pend && !ie))
          begin
            case (mode)
              lpm_pkg::LPM_ACTIVE:
              begin
                if (i_avs_writedata[lpm_pkg::CMD_SBY_BIT])
                begin
                  next_mode = lpm_pkg::LPM_STANDBY;
                end
                else if (i_avs_writedata[lpm_pkg::CMD_STOP_BIT])
                begin
                  next_mode = watch_sel ? lpm_pkg::LPM_WATCH : lpm_pkg::LPM_STOP;
                end
              end
              lpm_pkg::LPM_SUBACTIVE:
              begin
                // flags pick watch or direct active
                if (i_avs_writedata[1:0] != 2'h0)
                begin
                  if (!low_speed_flag && direct_transfer_flag)
                  begin
                    next_mode = lpm_pkg::LPM_DIRECT;
                    next_settle = 32'h0;
                  end
                  else
                  begin
                    next_mode = lpm_pkg::LPM_WATCH;
                  end
                end
              end
              default: next_mode = mode;
            endcase
          end
        end
        default: next_mode = next_mode;
      endcase
    end
    if (rd)
    begin
      case (i_avs_address)
        lpm_pkg::REG_MIS: next_rdata = {28'h0, frame_length_register};
        lpm_pkg::REG_LSDT: next_rdata = {28'h0, direct_transfer_flag, 2'h0, low_speed_flag};
        lpm_pkg::REG_RAMV: next_rdata = {28'h0, ramv, 3'h0};
        lpm_pkg::REG_STAT: next_rdata = {29'h0, mode};
        lpm_pkg::REG_IRQ: next_rdata = {29'h0, watch_sel, pend, ie};
        default: next_rdata = 32'h0;
      endcase
    end
    case (mode)
      lpm_pkg::LPM_STANDBY:
      begin
        if (wirq || tirq || i_timer_a_ovf)
        begin
          next_mode = lpm_pkg::LPM_ACTIVE;
        end
      end
      lpm_pkg::LPM_STOP:
      begin
        // cancel pin only acts in stop
        if (!i_stop_cancel_pin_n)
        begin
          next_mode = lpm_pkg::LPM_ACTIVE;
          next_restart = 1'b1;
          // pin exit leaves ram flag set
          next_ramv = 1'b1;
        end
      end
      lpm_pkg::LPM_WATCH:
      begin
        if (wirq || tirq)
        begin
          next_mode = low_speed_flag ? lpm_pkg::LPM_SUBACTIVE : lpm_pkg::LPM_ACTIVE;
        end
      end
      lpm_pkg::LPM_DIRECT:
      begin
        // settle after frame alignment bounds time
        if (settle >= 32'(SETTLE_CYCLES))
        begin
          next_mode = lpm_pkg::LPM_ACTIVE;
        end
        else if (settle != 32'h0 || frame)
        begin
          next_settle = settle + 32'h1;
        end
      end
      default: next_mode = next_mode;
    endcase
    if (next_mode == lpm_pkg::LPM_ACTIVE)
    begin
      next_direct_transfer_flag = 1'b0;
    end
  end

  // reset returns to active from any mode
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      mode <= lpm_pkg::LPM_ACTIVE;
      // sub stop bit cleared here, loaded by SCS writes
      scs <= lpm_pkg::SCS_RESET;
      frame_length_register <= lpm_pkg::MIS_RESET;
      low_speed_flag <= 1'b0;
      direct_transfer_flag <= 1'b0;
      ramv <= 1'b0;
      ie <= 1'b0;
      pend <= 1'b0;
      watch_sel <= 1'b0;
      settle <= 32'h0;
      rdata <= 32'h0;
      ack <= 1'b0;
      restart <= 1'b1;
      wake_s <= 1'b1;
      wake_prev <= 1'b1;
      edge_wait <= 2'h0;
      wirq <= 1'b0;
      tirq <= 1'b0;
      tovf_hold <= 1'b0;
      frame_ticks <= 5'h00;
      o_main_osc_en <= 1'b1;
      o_sub_osc_en <= 1'b1;
      o_adc_en <= 1'b1;
      o_cpu_run <= 1'b1;
      o_avs_waitrequest <= 1'b1;
    end
    else
    begin
      mode <= next_mode;
      scs <= next_scs;
      frame_length_register <= next_mis;
      low_speed_flag <= next_low_speed_flag;
      direct_transfer_flag <= next_direct_transfer_flag;
      ramv <= next_ramv;
      ie <= next_ie;
      pend <= next_pend;
      watch_sel <= next_watch_sel;
      settle <= next_settle;
      rdata <= next_rdata;
      ack <= next_ack;
      restart <= next_restart;
      wake_s <= next_wake_s;
      wake_prev <= next_wake_prev;
      edge_wait <= next_edge_wait;
      wirq <= next_wirq;
      tirq <= next_tirq;
      tovf_hold <= next_tovf_hold;
      frame_ticks <= next_frame_ticks;
      // oscillator and A/D enables per mode
      o_main_osc_en <= (next_mode == lpm_pkg::LPM_ACTIVE)
        || (next_mode == lpm_pkg::LPM_STANDBY) || (next_mode == lpm_pkg::LPM_DIRECT);
      o_sub_osc_en <= !((next_mode == lpm_pkg::LPM_STOP) && next_scs[lpm_pkg::SUBSTOP_BIT]);
      o_adc_en <= (next_mode == lpm_pkg::LPM_ACTIVE) || (next_mode == lpm_pkg::LPM_STANDBY);
      o_cpu_run <= (next_mode == lpm_pkg::LPM_ACTIVE) || (next_mode == lpm_pkg::LPM_SUBACTIVE);
      o_avs_waitrequest <= !next_ack;
    end
  end

  assign o_avs_readdata = rdata;
  assign o_restart_at_zero = restart;
  assign o_wake_irq = wirq;
  assign o_timer_irq = tirq;
endmodule // lpm_ctrl
`default_nettype wire

// ===== test/lpm_ctrl_asserts.sv
/*
 port checker for lpm_ctrl, bound to every instance;
 assumes the one clock and synchronous reset of the block
*/
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_asserts (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_stop_cancel_pin_n,
  input wire logic o_main_osc_en,
  input wire logic o_sub_osc_en,
  input wire logic o_adc_en,
  input wire logic o_cpu_run,
  input wire logic o_restart_at_zero,
  input wire logic o_wake_irq,
  input wire logic o_timer_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  ack_one_cycle_a: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  ack_bound_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |-> ##[1:2] !o_avs_waitrequest) else $error("request not answered");
  rst_state_a: assert property (disable iff (1'b0) i_reset |=> o_restart_at_zero && o_cpu_run
    && o_main_osc_en && o_adc_en && !o_timer_irq && !o_wake_irq) else $error("reset state");
  restart_cause_a: assert property ($rose(o_restart_at_zero) |-> !$past(i_stop_cancel_pin_n))
    else $error("restart without cause");
  restart_pulse_a: assert property (o_restart_at_zero && !$past(i_reset) |=> !o_restart_at_zero)
    else $error("restart not a pulse");
  adc_main_a: assert property (o_adc_en |-> o_main_osc_en)
    else $error("adc on without main clock");
  sub_halt_a: assert property (!o_sub_osc_en |-> !o_cpu_run && !o_main_osc_en && !o_adc_en)
    else $error("sub clock off outside stop");
  irq_pulse_a: assert property (o_timer_irq || o_wake_irq |=> !o_timer_irq && !o_wake_irq)
    else $error("wake request not a pulse");
  irq_mode_a: assert property (o_timer_irq || o_wake_irq |-> !o_adc_en)
    else $error("wake request in active mode");
  cover property ($rose(o_restart_at_zero));
  cover property (o_timer_irq);
  cover property (o_cpu_run && !o_main_osc_en);
endmodule // lpm_ctrl_asserts
bind lpm_ctrl lpm_ctrl_asserts u_asserts (.i_clk(i_clk), .i_reset(i_reset),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .i_stop_cancel_pin_n(i_stop_cancel_pin_n), .o_main_osc_en(o_main_osc_en),
  .o_sub_osc_en(o_sub_osc_en), .o_adc_en(o_adc_en), .o_cpu_run(o_cpu_run),
  .o_restart_at_zero(o_restart_at_zero), .o_wake_irq(o_wake_irq), .o_timer_irq(o_timer_irq));
`default_nettype wire

// ===== test/lpm_pin_model.sv
/*
 external pins around the block: stop cancel, wake pin, timer overflow;
 assumes the bench calls its tasks from its own sequence
*/
`timescale 1ns/1ps
`default_nettype none
module lpm_pin_model (
  input wire logic i_clk,
  output logic o_stop_cancel_pin_n,
  output logic o_wake_irq_pin_n,
  output logic o_timer_a_ovf
);
  initial
  begin
    o_stop_cancel_pin_n = 1'b1;
    o_wake_irq_pin_n = 1'b1;
    o_timer_a_ovf = 1'b0;
  end
  task automatic cancel(input int n);
    @(posedge i_clk);
    o_stop_cancel_pin_n <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_stop_cancel_pin_n <= 1'b1;
  endtask
  // falls once, then stays low far past a frame
  task automatic wake_fall;
    @(posedge i_clk);
    o_wake_irq_pin_n <= 1'b0;
  endtask
  task automatic ovf;
    @(posedge i_clk);
    o_timer_a_ovf <= 1'b1;
    @(posedge i_clk);
    o_timer_a_ovf <= 1'b0;
  endtask
endmodule // lpm_pin_model
`default_nettype wire

// ===== test/lpm_ctrl_bench.sv
/*
 self-checking bench for lpm_ctrl with an Avalon master;
 assumes lpm_pin_model drives the pins
*/
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_bench;
  logic i_clk, i_reset, rd_s, wr_s;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, q;
  logic cn, wn, ov, wreq, m_en, s_en, a_en, run, wi, ti;
  int err_total, comparisons, cyc, t0;
  lpm_ctrl #(.SETTLE_CYCLES(16)) u_dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_avs_address(addr), .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_stop_cancel_pin_n(cn),
    .i_wake_irq_pin_n(wn), .i_timer_a_ovf(ov), .o_main_osc_en(m_en), .o_sub_osc_en(s_en),
    .o_adc_en(a_en), .o_cpu_run(run), .o_restart_at_zero(), .o_wake_irq(wi),
    .o_timer_irq(ti));
  lpm_pin_model u_pins (.i_clk(i_clk), .o_stop_cancel_pin_n(cn), .o_wake_irq_pin_n(wn),
    .o_timer_a_ovf(ov));
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) cyc <= cyc + 1;
  task automatic stop_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr_s <= w;
    rd_s <= !w;
    @(posedge i_clk);
    while (wreq !== 1'b0)
    begin
      @(posedge i_clk);
      n++;
      if (n > 20)
      begin
        chk("waitrequest", 0, 1);
        stop_test();
      end
    end
    q = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    bus(1'b0, lpm_pkg::REG_STAT, 32'h0);
    while (q[2:0] !== m && n < 5000)
    begin
      bus(1'b0, lpm_pkg::REG_STAT, 32'h0);
      n++;
    end
    chk("mode wait", m, q);
  endtask
  task automatic stop_cycle(input logic [31:0] e);
    wr(lpm_pkg::REG_CMD, 32'h1);
    rdc("mode", lpm_pkg::REG_STAT, 32'h2);
    chk("sub osc", e, s_en);
  endtask
  initial
  begin
    i_reset = 1'b1;
    rd_s = 1'b0;
    wr_s = 1'b0;
    addr = 6'h00;
    wdata = 32'h0;
    err_total = 0;
    comparisons = 0;
    cyc = 0;
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    rdc("ram", lpm_pkg::REG_RAMV, 32'h0);
    rdc("clock select", lpm_pkg::REG_SCS, 32'h0);
    rdc("unmapped", 6'h3F, 32'h0);
    wr(lpm_pkg::REG_MIS, 32'h2);
    rdc("frame len", lpm_pkg::REG_MIS, 32'h2);
    wr(lpm_pkg::REG_MIS, 32'h0);
    u_pins.cancel(4);
    rdc("mode", lpm_pkg::REG_STAT, 32'h0);
    rdc("ram", lpm_pkg::REG_RAMV, 32'h0);
    wr(lpm_pkg::REG_LSDT, 32'h8);
    rdc("direct", lpm_pkg::REG_LSDT, 32'h0);
    wr(lpm_pkg::REG_IRQ, 32'h2);
    wr(lpm_pkg::REG_CMD, 32'h1);
    rdc("mode", lpm_pkg::REG_STAT, 32'h0);
    wr(lpm_pkg::REG_IRQ, 32'h0);
    wr(lpm_pkg::REG_SCS, 32'h8);
    stop_cycle(32'h0);
    u_pins.cancel(4);
    wait_mode(3'h0);
    rdc("ram", lpm_pkg::REG_RAMV, 32'h8);
    stop_cycle(32'h0);
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    rdc("mode", lpm_pkg::REG_STAT, 32'h0);
    rdc("ram", lpm_pkg::REG_RAMV, 32'h0);
    stop_cycle(32'h1);
    u_pins.cancel(4);
    wait_mode(3'h0);
    wr(lpm_pkg::REG_SCS, 32'h4);
    wr(lpm_pkg::REG_IRQ, 32'h4);
    wr(lpm_pkg::REG_LSDT, 32'h1);
    // lcd registers live outside this block
    wr(lpm_pkg::REG_CMD, 32'h1);
    rdc("mode", lpm_pkg::REG_STAT, 32'h3);
    u_pins.ovf();
    t0 = cyc;
    while (ti !== 1'b1 && cyc - t0 < lpm_pkg::SUB_CYC_FAST + 8) @(negedge i_clk);
    chk("timer irq", 1, ti);
    wait_mode(3'h4);
    chk("main osc", 0, m_en);
    chk("adc", 0, a_en);
    chk("cpu run", 1, run);
    u_pins.wake_fall();
    t0 = cyc;
    while (wi !== 1'b1 && cyc - t0 < 2 * lpm_pkg::SUB_CYC_FAST + 8) @(negedge i_clk);
    chk("wake irq", 1, wi);
    chk("wake late", 1, cyc - t0 >= lpm_pkg::SUB_CYC_FAST);
    wr(lpm_pkg::REG_LSDT, 32'h8);
    rdc("direct", lpm_pkg::REG_LSDT, 32'h8);
    wr(lpm_pkg::REG_CMD, 32'h1);
    t0 = cyc;
    wait_mode(3'h0);
    chk("direct min", 1, cyc - t0 > 16);
    chk("direct max", 1, cyc - t0 < lpm_pkg::FRAME_T0 * lpm_pkg::SUB_CYC_FAST + 32);
    rdc("direct", lpm_pkg::REG_LSDT, 32'h0);
    stop_test();
  end
endmodule // lpm_ctrl_bench
`default_nettype wire
